// file: design/i2c_slave_consts.svh
// Register offsets, field positions, reset values and timing for the two-wire slave
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH
`define ADDR_CTRL0 3'h0
`define ADDR_CTRL1 3'h1
`define ADDR_OWN 3'h2
`define ADDR_DATA 3'h3
`define ADDR_IRQEN 3'h4
`define MODE_TWO_WIRE 3'h6
`define CTRL0_EN_BIT 0
`define CTRL0_MODE_LO 1
`define CTRL1_RX_ACK_FLAG 0
`define CTRL1_DIR 2
`define CTRL1_TX_ACK_BIT 3
`define CTRL1_HTX 4
`define CTRL1_BUSY 5
`define CTRL1_MATCH 6
`define CTRL1_CF 7
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT 4'h9
`define RST_BYTE 8'h00
`endif

// file: design/i2c_slave_pkg.sv
// Types shared by the two-wire slave engine
`default_nettype none
package i2c_slave_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_HOLD = 3'b011,
        ST_DATA = 3'b100,
        ST_WAIT = 3'b101
    } eng_state_e;
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lines_s;
endpackage : i2c_slave_pkg
`default_nettype wire

// file: design/i2c_slave_protocol_engine.sv
// Slave-only two-wire serial engine with register port
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"
`default_nettype none
module i2c_slave_protocol_engine
    import i2c_slave_pkg::*;
(
    input wire logic clk, // System clock, 250 MHz
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic [2:0] reg_addr, // Register index
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic scl_in, // Clock line level
    output logic scl_out, // Clock line drive value
    output logic scl_oe, // Clock line drive enable
    input wire logic sda_in, // Data line level
    output logic sda_out, // Data line drive value
    output logic sda_oe, // Data line drive enable
    output logic irq // Bus interrupt request
);
    // Synchronisers: stage one read only by stage two
    bus_lines_s sync1_r, sync2_r, prev_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 2'b11;
            sync2_r <= 2'b11;
            prev_r <= 2'b11;
        end else begin
            sync1_r <= '{scl: scl_in, sda: sda_in};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Register state and engine state
    logic en_r, en_nxt;
    logic [2:0] mode_r, mode_nxt;
    logic [6:0] own_r, own_nxt;
    logic irq_en_r, irq_en_nxt;
    logic htx_r, htx_nxt;
    logic tx_ack_bit_r, tx_ack_bit_nxt;
    logic rx_ack_flag_r, rx_ack_flag_nxt;
    logic dir_r, dir_nxt;
    logic busy_r, busy_nxt;
    logic match_r, match_nxt;
    logic cf_r, cf_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] data_r, data_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic sda_drv_r, sda_drv_nxt;
    logic hold_r, hold_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    eng_state_e st_r, st_nxt;

    logic active, scl_rise, scl_fall, start_det, stop_det, wr_data, rd_data;
    assign active = en_r && (mode_r == `MODE_TWO_WIRE);
    assign scl_rise = sync2_r.scl && !prev_r.scl;
    assign scl_fall = !sync2_r.scl && prev_r.scl;
    assign start_det = sync2_r.scl && prev_r.scl && prev_r.sda && !sync2_r.sda;
    assign stop_det = sync2_r.scl && prev_r.scl && !prev_r.sda && sync2_r.sda;
    assign wr_data = reg_wr && (reg_addr == `ADDR_DATA);
    assign rd_data = reg_rd && (reg_addr == `ADDR_DATA);

    // Open-drain outputs: only ever pull low; start is never driven
    assign sda_out = 1'b0;
    assign sda_oe = sda_drv_r;
    assign scl_out = 1'b0;
    assign scl_oe = hold_r;
    assign irq = irq_r;
    assign reg_rdata = rdata_r;

    // Next-state logic for registers and the bus engine
    always_comb begin
        en_nxt = en_r;
        mode_nxt = mode_r;
        own_nxt = own_r;
        irq_en_nxt = irq_en_r;
        htx_nxt = htx_r;
        tx_ack_bit_nxt = tx_ack_bit_r;
        rx_ack_flag_nxt = rx_ack_flag_r;
        dir_nxt = dir_r;
        busy_nxt = busy_r;
        match_nxt = match_r;
        cf_nxt = cf_r;
        irq_nxt = 1'b0;
        data_nxt = data_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        sda_drv_nxt = sda_drv_r;
        hold_nxt = hold_r;
        st_nxt = st_r;
        rdata_nxt = `RST_BYTE;
        // Register reads: one cycle latency
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL0: rdata_nxt = {4'h0, mode_r, en_r};
                `ADDR_CTRL1: rdata_nxt = {cf_r, match_r, busy_r, htx_r, tx_ack_bit_r, dir_r,
                                          1'b0, rx_ack_flag_r};
                `ADDR_OWN: rdata_nxt = {own_r, 1'b0};
                `ADDR_DATA: rdata_nxt = data_r;
                `ADDR_IRQEN: rdata_nxt = {7'h00, irq_en_r};
                default: rdata_nxt = `RST_BYTE;
            endcase
        end
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CTRL0: begin
                    en_nxt = reg_wdata[`CTRL0_EN_BIT];
                    mode_nxt = reg_wdata[`CTRL0_MODE_LO +: 3];
                end
                `ADDR_CTRL1: begin
                    htx_nxt = reg_wdata[`CTRL1_HTX];
                    tx_ack_bit_nxt = reg_wdata[`CTRL1_TX_ACK_BIT];
                end
                `ADDR_OWN: own_nxt = reg_wdata[7:1];
                `ADDR_DATA: data_nxt = reg_wdata;
                `ADDR_IRQEN: irq_en_nxt = reg_wdata[0];
                default: ;
            endcase
        end
        if (!active) begin
            st_nxt = ST_IDLE;
            busy_nxt = 1'b0;
            sda_drv_nxt = 1'b0;
            hold_nxt = 1'b0;
        end else if (start_det) begin
            busy_nxt = 1'b1;
            match_nxt = 1'b0;
            cnt_nxt = 4'h0;
            sda_drv_nxt = 1'b0;
            hold_nxt = 1'b0;
            st_nxt = ST_ADDR;
        end else if (stop_det) begin
            busy_nxt = 1'b0;
            sda_drv_nxt = 1'b0;
            hold_nxt = 1'b0;
            st_nxt = ST_IDLE;
        end else begin
            case (st_r)
                ST_IDLE: ;
                // Address and direction bits sampled on rising clock
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sync2_r.sda};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == `BITS_PER_BYTE) begin
                        if (shift_r[7:1] == own_r) begin
                            dir_nxt = shift_r[0];
                            match_nxt = 1'b1;
                            irq_nxt = irq_en_r;
                            sda_drv_nxt = 1'b1;
                            st_nxt = ST_ACK;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                // Ninth clock: hold or release ack, then stretch clock unless a sent byte was not acknowledged
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_drv_nxt = 1'b0;
                        if (match_r) begin
                            hold_nxt = 1'b1;
                            st_nxt = ST_HOLD;
                        end else if (htx_r && rx_ack_flag_r) begin
                            st_nxt = ST_WAIT;
                        end else begin
                            hold_nxt = 1'b1;
                            st_nxt = ST_HOLD;
                        end
                    end
                    if (scl_rise && htx_r && !match_r) begin
                        rx_ack_flag_nxt = sync2_r.sda;
                    end
                end
                // Clock stretched until software writes the data register when transmitting or reads it when receiving
                ST_HOLD: begin
                    if ((htx_r && wr_data) || (!htx_r && rd_data)) begin
                        hold_nxt = 1'b0;
                        cf_nxt = 1'b0;
                        match_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        shift_nxt = htx_r ? reg_wdata : shift_r;
                        sda_drv_nxt = htx_r && !reg_wdata[7];
                        st_nxt = ST_DATA;
                    end
                end
                // Eight data bits, MSB first
                ST_DATA: begin
                    if (scl_rise && !htx_r) begin
                        shift_nxt = {shift_r[6:0], sync2_r.sda};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (scl_fall && htx_r) begin
                        cnt_nxt = cnt_r + 4'h1;
                        shift_nxt = {shift_r[6:0], 1'b0};
                        sda_drv_nxt = (cnt_r < `BITS_PER_BYTE - 4'h1) && !shift_r[6];
                        if (cnt_r == `BITS_PER_BYTE - 4'h1) begin
                            cf_nxt = 1'b1;
                            irq_nxt = irq_en_r;
                            st_nxt = ST_ACK;
                        end
                    end
                    if (scl_fall && !htx_r && cnt_r == `BITS_PER_BYTE) begin
                        data_nxt = shift_r;
                        cf_nxt = 1'b1;
                        irq_nxt = irq_en_r;
                        sda_drv_nxt = !tx_ack_bit_r;
                        st_nxt = ST_ACK;
                    end
                end
                // No acknowledge: data line released, wait for stop
                ST_WAIT: sda_drv_nxt = 1'b0;
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    // Register stage for all state except the synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_r <= 1'b0;
            mode_r <= 3'h0;
            own_r <= 7'h00;
            irq_en_r <= 1'b0;
            htx_r <= 1'b0;
            tx_ack_bit_r <= 1'b0;
            rx_ack_flag_r <= 1'b0;
            dir_r <= 1'b0;
            busy_r <= 1'b0;
            match_r <= 1'b0;
            cf_r <= 1'b0;
            irq_r <= 1'b0;
            data_r <= `RST_BYTE;
            shift_r <= `RST_BYTE;
            cnt_r <= 4'h0;
            sda_drv_r <= 1'b0;
            hold_r <= 1'b0;
            rdata_r <= `RST_BYTE;
            st_r <= ST_IDLE;
        end else begin
            en_r <= en_nxt;
            mode_r <= mode_nxt;
            own_r <= own_nxt;
            irq_en_r <= irq_en_nxt;
            htx_r <= htx_nxt;
            tx_ack_bit_r <= tx_ack_bit_nxt;
            rx_ack_flag_r <= rx_ack_flag_nxt;
            dir_r <= dir_nxt;
            busy_r <= busy_nxt;
            match_r <= match_nxt;
            cf_r <= cf_nxt;
            irq_r <= irq_nxt;
            data_r <= data_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            sda_drv_r <= sda_drv_nxt;
            hold_r <= hold_nxt;
            rdata_r <= rdata_nxt;
            st_r <= st_nxt;
        end
    end

    // Checks next to the logic
    property p_start_busy;
        @(posedge clk) disable iff (!reset_n) (active && start_det) |=> busy_r;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy not set");
    property p_stop_idle;
        @(posedge clk) disable iff (!reset_n)
            (active && stop_det && !start_det) |=> (!busy_r && st_r == ST_IDLE);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not free bus");
    property p_no_start_drive;
        @(posedge clk) disable iff (!reset_n) sda_oe |-> (st_r == ST_ACK || st_r == ST_DATA);
    endproperty
    a_no_start_drive: assert property (p_no_start_drive) else $error("bad drive");
    property p_match_ack;
        @(posedge clk) disable iff (!reset_n) $rose(match_r) |-> (sda_oe && st_r == ST_ACK);
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("no ack on match");
    property p_match_irq;
        @(posedge clk) disable iff (!reset_n) ($rose(match_r) && irq_en_r) |-> irq;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("no irq on match");
    property p_hold_release;
        @(posedge clk) disable iff (!reset_n)
            (st_r == ST_HOLD && active && !start_det && !stop_det && htx_r && wr_data) |=> !scl_oe;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("no release");
    property p_hold_keep;
        @(posedge clk) disable iff (!reset_n)
            (st_r == ST_HOLD && !wr_data && !rd_data && active && !stop_det && !start_det)
                |=> scl_oe;
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("clock released early");
    property p_cf_irq;
        @(posedge clk) disable iff (!reset_n) ($rose(cf_r) && irq_en_r) |-> irq;
    endproperty
    a_cf_irq: assert property (p_cf_irq) else $error("no irq on byte");
    property p_mode_gate;
        @(posedge clk) disable iff (!reset_n) !active |=> (st_r == ST_IDLE && !sda_oe && !scl_oe);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("ran outside mode");
endmodule : i2c_slave_protocol_engine
`default_nettype wire

// file: verification/i2c_master_model.sv
// Two-wire bus master model with open-drain drives and stretch-aware clocking
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic scl_line, // Resolved clock line
    input wire logic sda_line, // Resolved data line
    output logic scl_drive, // High pulls the clock line low
    output logic sda_drive // High pulls the data line low
);
    int stall_ns = 0; // Extra low time for a slow master
    // Both lines released until the first frame
    initial begin
        scl_drive = 1'b0;
        sda_drive = 1'b0;
    end
    // Release the clock, wait out a stretch; bounded so a stuck slave cannot hang us
    task automatic clk_high();
        int n;
        n = 0;
        scl_drive = 1'b0;
        #4;
        while (line_low() && n < 5000) begin
            #4;
            n++;
        end
        #12;
    endtask : clk_high
    function automatic logic line_low();
        return scl_line !== 1'b1;
    endfunction : line_low
    // One clock of 32 ns plus stall_ns unless stretched: data set well after the fall, sampled before the next
    task automatic bit_io(input logic b, output logic s);
        sda_drive = ~b;
        #(8 + stall_ns);
        clk_high();
        s = sda_line;
        scl_drive = 1'b1;
        #8;
    endtask : bit_io
    // Only this side ever opens a frame
    task automatic start_cond();
        sda_drive = 1'b0;
        #16;
        clk_high();
        sda_drive = 1'b1;
        #16;
        scl_drive = 1'b1;
        #16;
    endtask : start_cond
    task automatic stop_cond();
        sda_drive = 1'b1;
        #16;
        clk_high();
        sda_drive = 1'b0;
        #16;
    endtask : stop_cond
    // Bytes go out most significant bit first; ack is the level seen on the ninth clock
    task automatic write_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
        bit_io(1'b1, ack);
    endtask : write_byte
    task automatic read_byte(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask : read_byte
endmodule : i2c_master_model
`default_nettype wire

// file: verification/i2c_slave_protocol_engine_tb.sv
// Self-checking bench for the two-wire slave engine against a master model
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"
`default_nettype none
module i2c_slave_protocol_engine_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, rd, b0, b1;
    logic scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda, ack;
    logic [6:0] own;
    i2c_slave_pkg::bus_lines_s line_s;
    int err_count = 0;
    int compares = 0;
    int irq_seen = 0;
    // 250 MHz clock; pulled-up lines sit low whenever either side pulls
    always #2 clk = ~clk;
    assign line_s = {~(scl_oe | m_scl), ~(sda_oe | m_sda)};
    i2c_slave_protocol_engine i2c_slave_protocol_engine_inst (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(line_s.scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(line_s.sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .irq(irq));
    i2c_master_model i2c_master_model_inst (
        .scl_line(line_s.scl), .sda_line(line_s.sda), .scl_drive(m_scl), .sda_drive(m_sda));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Count interrupt pulses; the engine may only ever pull lines low
    always @(posedge clk) begin
        if (irq === 1'b1) begin
            irq_seen++;
        end
        if (reset_n && (scl_out | sda_out) !== 1'b0) begin
            check(8'h01, 8'h00);
        end
    end
    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read
    // Expected busy, matched and direction bits of the status register
    function automatic logic [7:0] status(input logic busy, input logic match, input logic dir);
        return {1'b0, match, busy, 2'b00, dir, 2'b00};
    endfunction : status
    // Open a frame, send an address, check answer, interrupt, stretch and status
    task automatic addr_phase(input logic [7:0] a, input logic [7:0] ack_exp,
                              input logic [7:0] irq_exp, input logic [7:0] st_exp);
        int n0;
        n0 = irq_seen;
        i2c_master_model_inst.start_cond();
        i2c_master_model_inst.write_byte(a, ack);
        check(8'(ack), ack_exp);
        check(8'(irq_seen - n0), irq_exp);
        reg_read(`ADDR_CTRL1, rd);
        check(rd & 8'h64, st_exp);
        check(8'(scl_oe), irq_exp);
    endtask : addr_phase
    task automatic finish_frame();
        i2c_master_model_inst.stop_cond();
        reg_read(`ADDR_CTRL1, rd);
        check(rd & 8'h20, 8'h00);
    endtask : finish_frame
    // Master writes two bytes; the second is refused through the tx ack bit
    task automatic write_xfer(input logic [7:0] d0, input logic [7:0] d1);
        addr_phase({own, 1'b0}, 8'h00, 8'h01, status(1'b1, 1'b1, 1'b0));
        reg_write(`ADDR_CTRL1, 8'h00);
        reg_read(`ADDR_DATA, rd);
        i2c_master_model_inst.write_byte(d0, ack);
        check(8'(ack), 8'h00);
        reg_read(`ADDR_CTRL1, rd);
        check(rd & 8'hc0, 8'h80);
        reg_write(`ADDR_CTRL1, 8'h08);
        reg_read(`ADDR_DATA, rd);
        check(rd, d0);
        i2c_master_model_inst.write_byte(d1, ack);
        check(8'(ack), 8'h01);
        reg_read(`ADDR_DATA, rd);
        check(rd, d1);
        finish_frame();
    endtask : write_xfer
    // Master reads two bytes and refuses the second
    task automatic read_xfer(input logic [7:0] d0, input logic [7:0] d1);
        addr_phase({own, 1'b1}, 8'h00, 8'h01, status(1'b1, 1'b1, 1'b1));
        reg_write(`ADDR_CTRL1, 8'h10);
        reg_write(`ADDR_DATA, d0);
        reg_read(`ADDR_CTRL1, rd);
        check(rd & 8'h80, 8'h00);
        i2c_master_model_inst.read_byte(rd, 1'b0);
        check(rd, d0);
        reg_read(`ADDR_CTRL1, rd);
        check(rd & 8'h81, 8'h80);
        reg_write(`ADDR_DATA, d1);
        i2c_master_model_inst.read_byte(rd, 1'b1);
        check(rd, d1);
        reg_read(`ADDR_CTRL1, rd);
        check(rd & 8'h01, 8'h01);
        finish_frame();
    endtask : read_xfer
    task automatic complete_run();
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // Main sequence: reset, map checks, refusals, then mixed transfers
    initial begin
        void'($urandom(86));
        own = 7'($urandom);
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reg_read(`ADDR_CTRL1, rd);
        check(rd, 8'h00);
        reg_write(3'h5, 8'hff);
        reg_read(3'h5, rd);
        check(rd, 8'h00);
        reg_write(`ADDR_OWN, {own, 1'b1});
        reg_read(`ADDR_OWN, rd);
        check(rd & 8'hfe, {own, 1'b0});
        reg_write(`ADDR_CTRL0, 8'h03);
        addr_phase({own, 1'b0}, 8'h01, 8'h00, 8'h00);
        i2c_master_model_inst.stop_cond();
        reg_write(`ADDR_CTRL0, {4'h0, `MODE_TWO_WIRE, 1'b1});
        reg_write(`ADDR_IRQEN, 8'h01);
        reg_read(`ADDR_CTRL0, rd);
        check(rd, {4'h0, `MODE_TWO_WIRE, 1'b1});
        reg_read(`ADDR_IRQEN, rd);
        check(rd, 8'h01);
        addr_phase({own ^ 7'h40, 1'b0}, 8'h01, 8'h00, status(1'b1, 1'b0, 1'b0));
        finish_frame();
        for (int i = 0; i < 3; i++) begin
            i2c_master_model_inst.stall_ns = 24 * i;
            b0 = (i == 0) ? 8'h80 : 8'($urandom);
            b1 = (i == 0) ? 8'h01 : 8'($urandom);
            write_xfer(b0, b1);
            read_xfer(~b0, 8'($urandom));
        end
        complete_run();
    end
    // Watchdog far beyond the roughly eleven microseconds the traffic needs
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule : i2c_slave_protocol_engine_tb
`default_nettype wire
